/* memsel_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - code memory is four equal blocks, each enabled only by its own select
// - with an 8-bit host bus code memory reads as bytes
// - with a 16-bit host bus code memory reads as 16-bit words
// - scratch ram is 2K bytes or 1K words, enabled only by its select
// - after an address change memory wakes, drives, latches data, then standby
// - ram or peripheral overlap wins and suppresses the code block select
// - separate space: code only on fetch strobe, ram data on read strobe
// - combined space: fetch or read strobe may reach code memory
// - read strobe may join block decodes; access then timed from read strobe
// - ram code bit lets fetch read ram, with ram winning over code
// - peripheral port enable bit must be set before port A peripheral mode
// - upper six bits of the mode register are reserved and read zero
// - port A is driven only during peripheral accesses, else released
// - either peripheral select enables the port A driver
// - host write drives port A outward, host read leaves it inward
// - direction bits zero release the two address ports for dma
// - address ports drive latched host address bits for the whole access
module memsel_top
  import memsel_pkg::*;
#(
  parameter int BLOCK_BYTES = memsel_pkg::BLOCK_BYTES_DEF
) (
  // clock and reset
  input  wire logic                        CLK_SYS_IN,
  input  wire logic                        SYS_RST_IN,
  // wishbone slave
  input  wire logic                        WB_CYC_IN,
  input  wire logic                        WB_STB_IN,
  input  wire logic                        WB_WE_IN,
  input  wire logic [7:0]                  WB_ADR_IN,
  input  wire logic [3:0]                  WB_SEL_IN,
  input  wire logic [31:0]                 WB_DAT_IN,
  output logic      [31:0]                 WB_DAT_OUT,
  output logic                             WB_ACK_OUT,
  // host bus
  input  wire logic [memsel_pkg::ADDR_W-1:0] HOST_ADDR_IN,
  input  wire logic [memsel_pkg::DATA_W-1:0] HOST_DATA_IN,
  output logic      [memsel_pkg::DATA_W-1:0] HOST_DATA_OUT,
  output logic                             HOST_DATA_OE_N_OUT,
  input  wire logic                        CODE_FETCH_STROBE_N_IN,
  input  wire logic                        HOST_RD_N_IN,
  input  wire logic                        HOST_WR_N_IN,
  input  wire logic                        HOST_ALE_IN,
  // decode array selects, active high
  input  wire logic [3:0]                  CODE_BLOCK_SELECT_IN,
  input  wire logic                        SCRATCH_RAM_SELECT_IN,
  input  wire logic                        PERIPHERAL_SELECT_A_IN,
  input  wire logic                        PERIPHERAL_SELECT_B_IN,
  // port A, peripheral data bus
  input  wire logic [7:0]                  PORTA_IN,
  output logic      [7:0]                  PORTA_OUT,
  output logic                             PORTA_OE_N_OUT,
  // address output ports
  output logic      [7:0]                  PORTC_OUT,
  output logic      [7:0]                  PORTC_OE_N_OUT,
  output logic      [7:0]                  PORTD_OUT,
  output logic      [7:0]                  PORTD_OE_N_OUT
);
  import memsel_pkg::*;

  localparam int BLK_AW   = $clog2(BLOCK_BYTES);
  localparam int CODE_AW  = BLK_AW + 1;
  localparam int CODE_DEP = CODE_BLOCKS * BLOCK_BYTES / 2;
  localparam int RAM_AW   = $clog2(RAM_BYTES / 2);

  typedef struct packed {
    host_pins_t          s1;
    host_pins_t          s2;
    logic                wr_prev;
    mem_state_t          st;
    logic [ADDR_W-1:0]   prev_addr;
    target_t             prev_tgt;
    logic [DATA_W-1:0]   out_latch;
    logic                host_oe;
    logic [7:0]          porta_out;
    logic                porta_drive;
    logic [7:0]          mode;
    logic [7:0]          cfg;
    logic [7:0]          dir_c;
    logic [7:0]          dir_d;
    logic [CODE_AW-1:0]  prog_addr;
    logic                ack;
    logic [31:0]         rdat;
  } top_state_t;

  top_state_t        q_r;
  top_state_t        q_nxt;
  host_pins_t        pins;
  host_pins_t        p;
  logic              fetch_act;
  logic              rd_act;
  logic              wr_act;
  logic              bus16;
  logic              combined;
  logic              code_strobe;
  logic              ram_claim;
  logic              pio_claim;
  logic              code_hit;
  logic              sram_hit;
  logic              pio_hit;
  target_t           tgt;
  logic              wb_req;
  logic              wb_wr;
  logic              code_we;
  logic              ram_we;
  logic [1:0]        ram_be;
  logic [15:0]       ram_wdata;
  logic              mem_re;
  logic [CODE_AW-1:0] code_raddr;
  logic [15:0]       code_rdata;
  logic [15:0]       ram_rdata;
  logic [15:0]       word_sel;
  logic [7:0]        portd_addr;

  // one-hot block select to block number
  function automatic logic [1:0] block_index(input logic [3:0] sel);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 0; i < CODE_BLOCKS; i++) begin
      if (sel[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction : block_index

  // byte-lane merge of a wishbone write into an 8-bit register
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [7:0] mask);
    logic [7:0] v;
    v = WB_SEL_IN[0] ? ((WB_DAT_IN[7:0] & mask) | (old & ~mask)) : old;
    return v;
  endfunction : lane0

  // pins gathered into one word for the two-stage synchroniser
  assign pins = '{addr: HOST_ADDR_IN, data: HOST_DATA_IN, fetch_n: CODE_FETCH_STROBE_N_IN,
                  rd_n: HOST_RD_N_IN, wr_n: HOST_WR_N_IN, ale: HOST_ALE_IN,
                  code_sel: CODE_BLOCK_SELECT_IN, ram_sel: SCRATCH_RAM_SELECT_IN,
                  psel_a: PERIPHERAL_SELECT_A_IN, psel_b: PERIPHERAL_SELECT_B_IN,
                  porta: PORTA_IN};
  assign p = q_r.s2;

  // strobe decode and overlap priority
  always_comb begin
    fetch_act   = ~p.fetch_n;
    rd_act      = ~p.rd_n;
    wr_act      = ~p.wr_n;
    bus16       = q_r.cfg[CFG_BUS16_BIT];
    combined    = q_r.cfg[CFG_COMBINED_BIT];
    code_strobe = combined ? (fetch_act | rd_act) : fetch_act;
    pio_claim   = q_r.mode[MODE_PIO_BIT] & (p.psel_a | p.psel_b);
    ram_claim   = p.ram_sel & (rd_act | wr_act |
                  (fetch_act & (q_r.mode[MODE_RAMCODE_BIT] | combined)));
    pio_hit     = pio_claim & (rd_act | wr_act);
    sram_hit    = ram_claim & ~pio_claim;
    code_hit    = (|p.code_sel) & code_strobe & ~ram_claim & ~pio_claim;
    if (pio_hit) begin
      tgt = TG_PIO;
    end else if (sram_hit) begin
      tgt = TG_RAM;
    end else if (code_hit) begin
      tgt = TG_CODE;
    end else begin
      tgt = TG_NONE;
    end
  end

  // memory ports; code word index is block number over offset in block
  always_comb begin
    code_raddr = {block_index(p.code_sel), q_r.prev_addr[BLK_AW-1:1]};
    mem_re     = (q_r.st == MS_WAKE);
    ram_we     = sram_hit & wr_act & ~q_r.wr_prev;
    ram_be     = bus16 ? 2'b11 : (p.addr[0] ? 2'b10 : 2'b01);
    ram_wdata  = bus16 ? p.data : {p.data[7:0], p.data[7:0]};
    wb_req     = WB_CYC_IN & WB_STB_IN & ~q_r.ack;
    wb_wr      = wb_req & WB_WE_IN;
    code_we    = wb_wr & (WB_ADR_IN == OFS_PDATA) & (&WB_SEL_IN[1:0]);
    portd_addr = bus16 ? p.addr[15:8] : p.addr[7:0];
  end

  // word picked for the host; byte mode chooses a half by address bit 0
  always_comb begin
    case (q_r.prev_tgt)
      TG_CODE: word_sel = code_rdata;
      TG_RAM:  word_sel = ram_rdata;
      // peripheral byte on both halves so odd addresses on a byte bus still see it
      TG_PIO:  word_sel = {p.porta, p.porta};
      default: word_sel = 16'h0000;
    endcase
  end

  // main next-state logic; reset is synchronous so it lives here too
  always_comb begin
    q_nxt         = q_r;
    q_nxt.s1      = pins;
    q_nxt.s2      = q_r.s1;
    q_nxt.wr_prev = wr_act;
    q_nxt.host_oe = (fetch_act | rd_act) & (tgt != TG_NONE);
    // port A: outward only on peripheral writes, inward otherwise
    q_nxt.porta_drive = pio_hit & wr_act;
    q_nxt.porta_out   = p.data[7:0];
    // memory wake sequence, started by a change of address or target while a fetch or read strobe hits a target
    case (q_r.st)
      MS_STANDBY: begin
        q_nxt.prev_addr = p.addr;
        q_nxt.prev_tgt  = (fetch_act | rd_act) ? tgt : TG_NONE;
        if (((fetch_act | rd_act) && tgt != TG_NONE) &&
            (p.addr != q_r.prev_addr || tgt != q_r.prev_tgt)) begin
          q_nxt.st = MS_WAKE;
        end
      end
      MS_WAKE: begin
        q_nxt.st = MS_DRIVE;
      end
      MS_DRIVE: begin
        if (bus16) begin
          q_nxt.out_latch = word_sel;
        end else begin
          q_nxt.out_latch = {8'h00, q_r.prev_addr[0] ? word_sel[15:8] : word_sel[7:0]};
        end
        q_nxt.st = MS_STANDBY;
      end
      default: begin
        q_nxt.st = MS_STANDBY;
      end
    endcase
    // wishbone slave: answer one cycle after the request
    q_nxt.ack = wb_req;
    if (wb_wr) begin
      case (WB_ADR_IN)
        OFS_MODE:  q_nxt.mode = lane0(q_r.mode, MODE_WMASK);
        OFS_CFG:   q_nxt.cfg = lane0(q_r.cfg, CFG_WMASK);
        OFS_DIRC:  q_nxt.dir_c = lane0(q_r.dir_c, 8'hFF);
        OFS_DIRD:  q_nxt.dir_d = lane0(q_r.dir_d, 8'hFF);
        OFS_PADDR: q_nxt.prog_addr = WB_DAT_IN[CODE_AW-1:0];
        OFS_PDATA: q_nxt.prog_addr = q_r.prog_addr + CODE_AW'(1);
        default:   q_nxt.mode = q_r.mode;
      endcase
    end
    if (wb_req && !WB_WE_IN) begin
      case (WB_ADR_IN)
        OFS_MODE:  q_nxt.rdat = {24'h000000, q_r.mode};
        OFS_CFG:   q_nxt.rdat = {24'h000000, q_r.cfg};
        OFS_DIRC:  q_nxt.rdat = {24'h000000, q_r.dir_c};
        OFS_DIRD:  q_nxt.rdat = {24'h000000, q_r.dir_d};
        OFS_STAT:  q_nxt.rdat = {26'h0000000, q_r.porta_drive, q_r.host_oe,
                                 q_r.prev_tgt, q_r.st};
        OFS_PADDR: q_nxt.rdat = 32'(q_r.prog_addr);
        default:   q_nxt.rdat = 32'h00000000; // unmapped reads as zero
      endcase
    end
    if (SYS_RST_IN) begin
      q_nxt       = '0;
      q_nxt.s1    = pins;
      q_nxt.s2    = q_r.s1; // keep flushing so strobes are not seen active after release
      q_nxt.mode  = MODE_RST;
      q_nxt.cfg   = CFG_RST;
      q_nxt.dir_c = DIR_RST;
      q_nxt.dir_d = DIR_RST;
      q_nxt.st    = MS_STANDBY;
      q_nxt.prev_tgt = TG_NONE;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    q_r <= q_nxt;
  end

  // code store, loaded word by word through the programming window
  memsel_mem #(.DEPTH(CODE_DEP), .AW(CODE_AW)) u_code_mem (
    .clk_in    (CLK_SYS_IN),
    .we_in     (code_we),
    .be_in     (2'b11),
    .waddr_in  (q_r.prog_addr),
    .wdata_in  (WB_DAT_IN[15:0]),
    .re_in     (mem_re),
    .raddr_in  (code_raddr),
    .rdata_out (code_rdata)
  );

  // scratch ram, written once per host write strobe
  memsel_mem #(.DEPTH(RAM_BYTES / 2), .AW(RAM_AW)) u_ram_mem (
    .clk_in    (CLK_SYS_IN),
    .we_in     (ram_we),
    .be_in     (ram_be),
    .waddr_in  (p.addr[RAM_AW:1]),
    .wdata_in  (ram_wdata),
    .re_in     (mem_re),
    .raddr_in  (q_r.prev_addr[RAM_AW:1]),
    .rdata_out (ram_rdata)
  );

  // address out ports; port D carries the high byte on a 16-bit bus
  memsel_addr_port u_port_c (
    .clk_in        (CLK_SYS_IN),
    .rst_in        (SYS_RST_IN),
    .ale_in        (p.ale),
    .addr_in       (p.addr[7:0]),
    .dir_in        (q_r.dir_c),
    .port_out      (PORTC_OUT),
    .port_oe_n_out (PORTC_OE_N_OUT)
  );

  memsel_addr_port u_port_d (
    .clk_in        (CLK_SYS_IN),
    .rst_in        (SYS_RST_IN),
    .ale_in        (p.ale),
    .addr_in       (portd_addr),
    .dir_in        (q_r.dir_d),
    .port_out      (PORTD_OUT),
    .port_oe_n_out (PORTD_OE_N_OUT)
  );

  // outputs straight from flops
  assign WB_ACK_OUT         = q_r.ack;
  assign WB_DAT_OUT         = q_r.rdat;
  assign HOST_DATA_OUT      = q_r.out_latch;
  assign HOST_DATA_OE_N_OUT = ~q_r.host_oe;
  assign PORTA_OUT          = q_r.porta_out;
  assign PORTA_OE_N_OUT     = ~q_r.porta_drive;

  // checks on the internal decode and port behaviour
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);

  a_ram_over_code: assert property (ram_claim |-> !code_hit)
    else $error("code selected while ram claims the access");
  a_sep_fetch_only: assert property (!combined && code_hit |-> fetch_act)
    else $error("separate space code access without fetch strobe");
  a_comb_strobes: assert property (code_hit |-> (fetch_act || rd_act))
    else $error("code access without fetch or read strobe");
  a_ram_fetch_wins: assert property
    (fetch_act && p.ram_sel && q_r.mode[MODE_RAMCODE_BIT] && !pio_claim |-> tgt == TG_RAM)
    else $error("ram code fetch not served by ram");
  a_ram_we_gate: assert property (ram_we |-> p.ram_sel && wr_act)
    else $error("ram written without its select");
  a_porta_needs_en: assert property (!PORTA_OE_N_OUT |-> $past(q_r.mode[MODE_PIO_BIT]))
    else $error("port A driven with peripheral mode off");
  a_porta_write: assert property (pio_hit && wr_act |=> !PORTA_OE_N_OUT)
    else $error("port A not driven on peripheral write");
  a_porta_read_in: assert property (pio_hit && rd_act && !wr_act |=> PORTA_OE_N_OUT)
    else $error("port A driven during peripheral read");
  a_porta_idle: assert property (!(p.psel_a || p.psel_b) |=> PORTA_OE_N_OUT)
    else $error("port A driven outside peripheral access");
  a_wake_seq: assert property
    (q_r.st == MS_WAKE |=> q_r.st == MS_DRIVE ##1 q_r.st == MS_STANDBY)
    else $error("wake sequence did not return to standby in two cycles");
  a_mode_reserved: assert property (q_r.mode[7:2] == 6'h00)
    else $error("reserved mode bits set");
  a_mode_reset: assert property ($past(SYS_RST_IN) |-> q_r.mode == MODE_RST)
    else $error("mode register not cleared by reset");

  c_code_read: cover property (q_r.st == MS_DRIVE && q_r.prev_tgt == TG_CODE);
  c_ram_fetch: cover property (fetch_act && tgt == TG_RAM);
  c_pio_write: cover property (pio_hit && wr_act ##1 !PORTA_OE_N_OUT);
endmodule : memsel_top
`default_nettype wire

/* memsel_pkg.sv */
`default_nettype none
package memsel_pkg;
  // host bus geometry
  localparam int ADDR_W          = 17;
  localparam int DATA_W          = 16;
  localparam int CODE_BLOCKS     = 4;
  localparam int BLOCK_BYTES_DEF = 32768;
  localparam int RAM_BYTES       = 2048;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] OFS_MODE  = 8'h00;
  localparam logic [7:0] OFS_CFG   = 8'h04;
  localparam logic [7:0] OFS_DIRC  = 8'h08;
  localparam logic [7:0] OFS_DIRD  = 8'h0C;
  localparam logic [7:0] OFS_STAT  = 8'h10;
  localparam logic [7:0] OFS_PADDR = 8'h14;
  localparam logic [7:0] OFS_PDATA = 8'h18;

  // field positions
  localparam int MODE_PIO_BIT     = 0;
  localparam int MODE_RAMCODE_BIT = 1;
  localparam logic [7:0] MODE_WMASK = 8'h03;
  localparam int CFG_COMBINED_BIT = 0;
  localparam int CFG_BUS16_BIT    = 1;
  localparam logic [7:0] CFG_WMASK  = 8'h03;

  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] DIR_RST  = 8'h00;

  typedef enum logic [1:0] {
    MS_STANDBY = 2'b00,
    MS_WAKE    = 2'b01,
    MS_DRIVE   = 2'b10
  } mem_state_t;

  typedef enum logic [1:0] {
    TG_NONE = 2'b00,
    TG_CODE = 2'b01,
    TG_RAM  = 2'b10,
    TG_PIO  = 2'b11
  } target_t;

  // every host-side pin the block samples, carried as one word through the synchroniser
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              fetch_n;
    logic              rd_n;
    logic              wr_n;
    logic              ale;
    logic [3:0]        code_sel;
    logic              ram_sel;
    logic              psel_a;
    logic              psel_b;
    logic [7:0]        porta;
  } host_pins_t;
endpackage : memsel_pkg
`default_nettype wire

/* memsel_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module memsel_mem #(
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  input  wire logic          clk_in,
  // write port with byte lanes
  input  wire logic          we_in,
  input  wire logic [1:0]    be_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [15:0]   wdata_in,
  // read port, data one cycle after re_in
  input  wire logic          re_in,
  input  wire logic [AW-1:0] raddr_in,
  output logic      [15:0]   rdata_out
);
  logic [15:0] mem [DEPTH];
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  // read data only moves on a wake cycle so it stays latched in standby
  always_comb begin
    rdata_nxt = re_in ? mem[raddr_in] : rdata_r;
  end

  always_ff @(posedge clk_in) begin
    rdata_r <= rdata_nxt;
    if (we_in && be_in[0]) begin
      mem[waddr_in][7:0] <= wdata_in[7:0];
    end
    if (we_in && be_in[1]) begin
      mem[waddr_in][15:8] <= wdata_in[15:8];
    end
  end

  assign rdata_out = rdata_r;
endmodule : memsel_mem
`default_nettype wire

/* memsel_addr_port.sv */
`timescale 1ns/1ps
`default_nettype none
module memsel_addr_port (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // latch strobe and address byte, already synchronised
  input  wire logic       ale_in,
  input  wire logic [7:0] addr_in,
  // direction bits, one means output
  input  wire logic [7:0] dir_in,
  // pin side
  output logic      [7:0] port_out,
  output logic      [7:0] port_oe_n_out
);
  typedef struct packed {
    logic [7:0] latched;
    logic [7:0] port;
    logic [7:0] oe_n;
  } aport_state_t;

  aport_state_t q_r;
  aport_state_t q_nxt;

  // transparent while ale, held afterwards so the peripheral bus stays stable
  always_comb begin
    q_nxt         = q_r;
    q_nxt.latched = ale_in ? addr_in : q_r.latched;
    q_nxt.port    = q_r.latched;
    q_nxt.oe_n    = ~dir_in;
    if (rst_in) begin
      q_nxt = '0;
      q_nxt.oe_n = '1;
    end
  end

  always_ff @(posedge clk_in) begin
    q_r <= q_nxt;
  end

  assign port_out      = q_r.port;
  assign port_oe_n_out = q_r.oe_n;
endmodule : memsel_addr_port
`default_nettype wire

/* periph_model.sv */
`timescale 1ns/1ps
`default_nettype none
// peripheral on the port A data bus; answers reads, otherwise never holds a stale level
module periph_model #(
  parameter logic [7:0] READ_BYTE = 8'h3C
) (
  input  wire logic       clk_in,
  input  wire logic       psel_in,
  input  wire logic       rd_n_in,
  input  wire logic       oe_n_in,
  input  wire logic [7:0] drv_in,
  output logic      [7:0] level_out
);
  logic [7:0] last_r;
  // block wins when it drives; we drive only while selected for a read
  always_comb begin
    if (!oe_n_in) level_out = drv_in;
    else if (psel_in && !rd_n_in) level_out = READ_BYTE;
    else level_out = ~last_r;  // released bus: no value survives
  end
  always_ff @(posedge clk_in) begin
    last_r <= level_out;
  end
endmodule : periph_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import memsel_pkg::*;
  logic clk, rst, cyc, stb, we, ale, fetch_n, rd_n, wr_n, ram, pa, pb;
  logic [7:0] adr, pa_lvl;
  logic [31:0] wdat, rq;
  logic [3:0] csel;
  logic [16:0] haddr;
  logic [15:0] hdata, hq;
  logic [31:0] wb_q;
  logic wb_ack, hoe_n, pa_oe_n;
  logic [7:0] pa_out, pc, pc_oe_n, pd, pd_oe_n;
  int miscompares, check_count;
  memsel_top #(.BLOCK_BYTES(8192)) DUT (.CLK_SYS_IN(clk), .SYS_RST_IN(rst),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(wb_q), .WB_ACK_OUT(wb_ack), .HOST_ADDR_IN(haddr),
    .HOST_DATA_IN(hdata), .HOST_DATA_OUT(hq), .HOST_DATA_OE_N_OUT(hoe_n),
    .CODE_FETCH_STROBE_N_IN(fetch_n), .HOST_RD_N_IN(rd_n), .HOST_WR_N_IN(wr_n),
    .HOST_ALE_IN(ale), .CODE_BLOCK_SELECT_IN(csel), .SCRATCH_RAM_SELECT_IN(ram),
    .PERIPHERAL_SELECT_A_IN(pa), .PERIPHERAL_SELECT_B_IN(pb), .PORTA_IN(pa_lvl),
    .PORTA_OUT(pa_out), .PORTA_OE_N_OUT(pa_oe_n), .PORTC_OUT(pc), .PORTC_OE_N_OUT(pc_oe_n),
    .PORTD_OUT(pd), .PORTD_OE_N_OUT(pd_oe_n));
  periph_model PM (.clk_in(clk), .psel_in(pa | pb), .rd_n_in(rd_n), .oe_n_in(pa_oe_n),
    .drv_in(pa_out), .level_out(pa_lvl));
  // free-running system clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // one classic wishbone cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rq = wb_q;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      results();
    end
  endtask : wb
  // host access: sel = {block selects, ram, peripheral a, peripheral b}
  task automatic host(input logic [2:0] strb, input logic [6:0] sel, input logic [16:0] a,
                      input logic [15:0] d);
    @(posedge clk);
    {fetch_n, rd_n, wr_n} <= strb; {csel, ram, pa, pb} <= sel; haddr <= a; hdata <= d;
    repeat (8) @(posedge clk);  // strobe held past the wake and drive steps
  endtask : host
  task automatic idle();
    @(posedge clk);
    {fetch_n, rd_n, wr_n} <= 3'b111; {csel, ram, pa, pb} <= 7'h00;
    repeat (4) @(posedge clk);
  endtask : idle
  task automatic t_regs();
    chk("porta_oe_n", 1, pa_oe_n);
    chk("portc_oe_n", 8'hFF, pc_oe_n);
    wb(0, OFS_MODE, 0); chk("mode_rst", 0, rq);
    wb(1, OFS_MODE, 32'hFF); wb(0, OFS_MODE, 0); chk("mode_rsv", 3, rq);
    wb(0, 8'h1C, 0); chk("unmapped", 0, rq);
    wb(1, OFS_MODE, 0);
  endtask : t_regs
  // load two blocks, read each through its own select
  task automatic t_code();
    wb(1, OFS_PADDR, 0); wb(1, OFS_PDATA, 32'hA55A);
    wb(1, OFS_PADDR, 32'h1000); wb(1, OFS_PDATA, 32'h5AA5);
    // byte bus: odd address returns the high byte in bits 7:0
    host(3'b011, 7'b0001000, 17'h1, 0); chk("byte_hi", 16'h00A5, hq); idle();
    wb(1, OFS_CFG, 2);
    host(3'b011, 7'b0001000, 17'h0, 0); chk("blk0", 16'hA55A, hq);
    chk("host_oe_n", 0, hoe_n); idle();
    host(3'b011, 7'b0010000, 17'h2000, 0); chk("blk1", 16'h5AA5, hq); idle();
  endtask : t_code
  task automatic t_ram();
    host(3'b110, 7'b0000100, 17'h0, 16'h1234); idle();
    host(3'b101, 7'b0001100, 17'h0, 0); chk("ram_over", 16'h1234, hq); idle();
    host(3'b101, 7'b0010000, 17'h2000, 0); chk("sep_rd_oe", 1, hoe_n); idle();
    host(3'b011, 7'b0001100, 17'h0, 0); chk("fetch_code", 16'hA55A, hq); idle();
    wb(1, OFS_MODE, 2);
    host(3'b011, 7'b0001100, 17'h0, 0); chk("fetch_ram", 16'h1234, hq); idle();
    wb(1, OFS_MODE, 0); wb(1, OFS_CFG, 3);
    host(3'b101, 7'b0010000, 17'h2000, 0); chk("comb_rd", 16'h5AA5, hq); idle();
    host(3'b101, 7'b0001100, 17'h0, 0); chk("comb_ram_over", 16'h1234, hq); idle();
  endtask : t_ram
  task automatic t_pio();
    host(3'b110, 7'b0000010, 17'h100, 16'h00C3); chk("pio_off", 1, pa_oe_n); idle();
    wb(1, OFS_MODE, 1);
    host(3'b110, 7'b0000010, 17'h101, 16'h00C3); chk("pio_wr_oe", 0, pa_oe_n);
    chk("pio_wr_d", 8'hC3, pa_out); idle(); chk("pio_rel", 1, pa_oe_n);
    // block 0 also selected: the peripheral must win over code memory
    host(3'b101, 7'b0001001, 17'h102, 0); chk("pio_rd_oe", 1, pa_oe_n);
    chk("pio_rd_d", 8'h3C, hq[7:0]); idle();
  endtask : t_pio
  // address out port follows the latched host address, released by direction zero
  task automatic t_addr();
    wb(1, OFS_DIRC, 32'hFF);
    @(posedge clk); haddr <= 17'h12A7; ale <= 1'b1;
    @(posedge clk); ale <= 1'b0;
    repeat (5) @(posedge clk); haddr <= 17'h0055;
    repeat (4) @(posedge clk);
    chk("portc", 8'hA7, pc); chk("portc_oe", 0, pc_oe_n);
    chk("portd", 8'h12, pd);
    wb(1, OFS_DIRC, 0); repeat (3) @(posedge clk);
    chk("portc_rel", 8'hFF, pc_oe_n); chk("portd_rel", 8'hFF, pd_oe_n);
  endtask : t_addr
  initial begin
    miscompares = 0; check_count = 0;
    rst = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; ale = 0;
    fetch_n = 1; rd_n = 1; wr_n = 1; csel = 0; ram = 0; pa = 0; pb = 0; haddr = 0; hdata = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs(); t_code(); t_ram(); t_pio(); t_addr();
    results();
  end
endmodule : tb
`default_nettype wire
